// File: rtl/hrlpc_pkg.sv
// Shared constants and types for the pause, reset and lane-three pin block
package hrlpc_pkg;

  localparam int          CLK_NS       = 4;
  localparam int          HOST_SCK_NS  = 32;
  localparam int          HALF_CYC     = HOST_SCK_NS / (2 * CLK_NS);
  localparam logic [1:0]  HALF_LAST    = 2'(HALF_CYC - 1);
  localparam int          RST_PULSE_NS = 1000;
  localparam int          RST_CYC      = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  RST_LAST     = 8'(RST_CYC - 1);
  localparam logic [3:0]  BIT_FIRST    = 4'h0;
  localparam logic [3:0]  BIT_DATA0    = 4'h8;
  localparam logic [3:0]  BIT_CMD_LAST = 4'h7;
  localparam logic [3:0]  BIT_LAST     = 4'hF;
  localparam int          CMD_READ_BIT = 7;

  typedef enum logic [1:0] {
    ROLE_PAUSE = 2'h0,
    ROLE_RESET = 2'h1,
    ROLE_LANE  = 2'h2
  } hrlpc_role_type;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_LOW   = 3'h1,
    H_HIGH  = 3'h3,
    H_END   = 3'h2,
    H_PAUSE = 3'h5,
    H_RST   = 3'h4
  } hrlpc_hstate_type;

  // Pin role from the two configuration bits
  function automatic hrlpc_role_type hrlpc_role(input logic qe, input logic hrs);
    if (qe) begin
      return ROLE_LANE;
    end
    return hrs ? ROLE_RESET : ROLE_PAUSE;
  endfunction : hrlpc_role

endpackage : hrlpc_pkg

// File: rtl/hrlpc_link_if.sv
// Serial link between the host end and the flash end
`timescale 1ns/10ps
`default_nettype none
interface hrlpc_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_dev;
  logic so_oe;
  logic hold_o;
  logic hold_oe;
  logic lane3_o;
  logic lane3_oe;
  logic so;
  logic lane3;

  // Wire levels with pull-ups when nobody drives
  assign so    = so_oe ? so_dev : 1'b1;
  assign lane3 = lane3_oe ? lane3_o : (hold_oe ? hold_o : 1'b1);

  modport dev (
    input  cs_n, sck, si, lane3,
    output so_dev, so_oe, lane3_o, lane3_oe
  );

  modport host (
    input  so, lane3,
    output cs_n, sck, si, hold_o, hold_oe
  );
endinterface : hrlpc_link_if
`default_nettype wire

// File: rtl/hrlpc_device.sv
// Flash end: multi-purpose pin role, pause handling and serial shifting
`timescale 1ns/10ps
`default_nettype none
module hrlpc_device
  import hrlpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  hrlpc_link_if.dev        link,
  input  wire logic        quad_lanes_enable_bit,
  input  wire logic        hold_reset_select,
  input  wire logic [7:0]  tx_data,
  output logic      [7:0]  rx_cmd,
  output logic      [7:0]  rx_data,
  output logic      [7:0]  rx_lane3,
  output logic             rx_valid,
  output logic             paused,
  output logic             hw_reset_req
);

  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [7:0] cmd;
    logic [7:0] sh_si;
    logic [7:0] sh_l3;
  } hrlpc_frm_type;

  typedef struct packed {
    logic       qe_s1;
    logic       qe_s2;
    logic       hrs_s1;
    logic       hrs_s2;
    logic       tog;
    logic [7:0] cap_cmd;
    logic [7:0] cap_si;
    logic [7:0] cap_l3;
  } hrlpc_lnk_type;

  typedef struct packed {
    logic so_oe;
    logic so;
    logic l3_oe;
    logic l3;
  } hrlpc_out_type;

  typedef struct packed {
    logic       tog_s1;
    logic       tog_s2;
    logic       tog_s3;
    logic       pau_s1;
    logic       pau_s2;
    logic       rst_s1;
    logic       rst_s2;
    logic       rx_valid;
    logic [7:0] rx_cmd;
    logic [7:0] rx_data;
    logic [7:0] rx_l3;
    logic       paused;
    logic       hw_reset_req;
  } hrlpc_usr_type;

  hrlpc_frm_type  f_r;
  hrlpc_frm_type  f_nxt;
  hrlpc_lnk_type  k_r;
  hrlpc_lnk_type  k_nxt;
  hrlpc_out_type  o_r;
  hrlpc_out_type  o_nxt;
  hrlpc_usr_type  u_r;
  hrlpc_usr_type  u_nxt;
  hrlpc_role_type role_l;
  hrlpc_role_type role_u;
  logic           hold_low;
  logic           advance;
  logic           data_ph;
  logic           quad_wr;
  logic           byte_done;

  // Link-side pin role and pause decode
  always_comb begin
    role_l    = hrlpc_role(k_r.qe_s2, k_r.hrs_s2);
    hold_low  = (role_l == ROLE_PAUSE) && !link.lane3 && !link.cs_n;
    advance   = !hold_low;
    data_ph   = f_r.bit_cnt[3];
    quad_wr   = (role_l == ROLE_LANE) && !f_r.cmd[CMD_READ_BIT];
    byte_done = advance && (f_r.bit_cnt == BIT_LAST);
  end

  // Frame shifter, sampled on the rising clock
  always_comb begin
    f_nxt = f_r;
    if (advance) begin
      if (f_r.bit_cnt == BIT_LAST) begin
        f_nxt.bit_cnt = BIT_DATA0;
      end else begin
        f_nxt.bit_cnt = f_r.bit_cnt + 4'h1;
      end
      if (!data_ph) begin
        f_nxt.cmd = {f_r.cmd[6:0], link.si};
      end else begin
        f_nxt.sh_si = {f_r.sh_si[6:0], link.si};
        if (quad_wr) begin
          f_nxt.sh_l3 = {f_r.sh_l3[6:0], link.lane3};
        end
      end
    end
  end

  // Chip select rise ends the frame and clears its state
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  // Config synchronisers and byte hand-off on the link clock
  always_comb begin
    k_nxt        = k_r;
    k_nxt.qe_s1  = quad_lanes_enable_bit;
    k_nxt.qe_s2  = k_r.qe_s1;
    k_nxt.hrs_s1 = hold_reset_select;
    k_nxt.hrs_s2 = k_r.hrs_s1;
    if (byte_done && !link.cs_n) begin
      k_nxt.tog     = !k_r.tog;
      k_nxt.cap_cmd = f_r.cmd;
      k_nxt.cap_si  = {f_r.sh_si[6:0], link.si};
      k_nxt.cap_l3  = quad_wr ? {f_r.sh_l3[6:0], link.lane3} : 8'h00;
    end
  end

  always_ff @(posedge link.sck or posedge sys_rst) begin
    if (sys_rst) begin
      k_r <= '0;
    end else begin
      k_r <= k_nxt;
    end
  end

  // Output lanes change on the falling clock
  always_comb begin
    o_nxt = o_r;
    if (advance) begin
      o_nxt.so_oe = data_ph && f_r.cmd[CMD_READ_BIT];
      o_nxt.so    = tx_data[~f_r.bit_cnt[2:0]];
      o_nxt.l3_oe = o_nxt.so_oe && (role_l == ROLE_LANE);
      o_nxt.l3    = tx_data[~f_r.bit_cnt[2:0]];
    end
  end

  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      o_r <= '0;
    end else begin
      o_r <= o_nxt;
    end
  end

  // Serial output enable released at once while paused; lane three enable is not gated
  assign link.so_dev   = o_r.so;
  assign link.so_oe    = o_r.so_oe && !hold_low;
  assign link.lane3_o  = o_r.l3;
  assign link.lane3_oe = o_r.l3_oe;

  // System clock side: event and level crossings
  always_comb begin
    role_u          = hrlpc_role(quad_lanes_enable_bit, hold_reset_select);
    u_nxt           = u_r;
    u_nxt.tog_s1    = k_r.tog;
    u_nxt.tog_s2    = u_r.tog_s1;
    u_nxt.tog_s3    = u_r.tog_s2;
    u_nxt.rx_valid  = u_r.tog_s2 ^ u_r.tog_s3;
    if (u_r.tog_s2 ^ u_r.tog_s3) begin
      u_nxt.rx_cmd  = k_r.cap_cmd;
      u_nxt.rx_data = k_r.cap_si;
      u_nxt.rx_l3   = k_r.cap_l3;
    end
    u_nxt.pau_s1       = !link.lane3 && !link.cs_n;
    u_nxt.pau_s2       = u_r.pau_s1;
    u_nxt.rst_s1       = !link.lane3;
    u_nxt.rst_s2       = u_r.rst_s1;
    u_nxt.paused       = u_r.pau_s2 && (role_u == ROLE_PAUSE);
    u_nxt.hw_reset_req = u_r.rst_s2 && (role_u == ROLE_RESET);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      u_r <= '0;
    end else begin
      u_r <= u_nxt;
    end
  end

  assign rx_cmd       = u_r.rx_cmd;
  assign rx_data      = u_r.rx_data;
  assign rx_lane3     = u_r.rx_l3;
  assign rx_valid     = u_r.rx_valid;
  assign paused       = u_r.paused;
  assign hw_reset_req = u_r.hw_reset_req;

endmodule : hrlpc_device
`default_nettype wire

// File: rtl/hrlpc_host.sv
// Host end: clock divider, frame sequencer, pause and reset pulses
`timescale 1ns/10ps
`default_nettype none
module hrlpc_host
  import hrlpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  hrlpc_link_if.host       link,
  input  wire logic        quad_lanes_enable_bit,
  input  wire logic        hold_reset_select,
  input  wire logic        start,
  input  wire logic [7:0]  cmd,
  input  wire logic [7:0]  wdata,
  input  wire logic        pause_req,
  input  wire logic        reset_req,
  output logic             busy,
  output logic             done,
  output logic      [7:0]  rdata,
  output logic      [7:0]  rdata_l3
);

  typedef struct packed {
    hrlpc_hstate_type st;
    logic [1:0]       div;
    logic [3:0]       bit_cnt;
    logic [15:0]      sh;
    logic [7:0]       cmd;
    logic [7:0]       rd;
    logic [7:0]       rd_l3;
    logic [7:0]       rst_cnt;
    logic             cs_n;
    logic             sck;
    logic             si;
    logic             hold_o;
    logic             hold_oe;
    logic             so_s1;
    logic             so_s2;
    logic             l3_s1;
    logic             l3_s2;
    logic             busy;
    logic             done;
  } hrlpc_host_type;

  localparam hrlpc_host_type H_RST_VAL = '{st: H_IDLE, cs_n: 1'b1, hold_o: 1'b1,
                                           hold_oe: 1'b1, default: '0};

  hrlpc_host_type h_r;
  hrlpc_host_type h_nxt;
  hrlpc_role_type role_h;

  always_comb begin
    role_h      = hrlpc_role(quad_lanes_enable_bit, hold_reset_select);
    h_nxt       = h_r;
    h_nxt.done  = 1'b0;
    h_nxt.so_s1 = link.so;
    h_nxt.so_s2 = h_r.so_s1;
    h_nxt.l3_s1 = link.lane3;
    h_nxt.l3_s2 = h_r.l3_s1;
    case (h_r.st)
      H_IDLE: begin
        h_nxt.cs_n    = 1'b1;
        h_nxt.sck     = 1'b0;
        h_nxt.hold_o  = 1'b1;
        h_nxt.hold_oe = (role_h != ROLE_LANE);
        h_nxt.busy    = 1'b0;
        if (reset_req && (role_h == ROLE_RESET)) begin
          h_nxt.st      = H_RST;
          h_nxt.rst_cnt = 8'h00;
          h_nxt.hold_o  = 1'b0;
          h_nxt.busy    = 1'b1;
        end else if (start) begin
          h_nxt.st      = H_LOW;
          h_nxt.cs_n    = 1'b0;
          h_nxt.sh      = {cmd, wdata};
          h_nxt.cmd     = cmd;
          h_nxt.si      = cmd[7];
          h_nxt.bit_cnt = BIT_FIRST;
          h_nxt.div     = 2'h0;
          h_nxt.busy    = 1'b1;
        end
      end
      H_LOW: begin
        h_nxt.div = h_r.div + 2'h1;
        if (h_r.div == HALF_LAST) begin
          h_nxt.div = 2'h0;
          if (pause_req && (role_h == ROLE_PAUSE)) begin
            h_nxt.st     = H_PAUSE;
            h_nxt.hold_o = 1'b0;
          end else begin
            h_nxt.st  = H_HIGH;
            h_nxt.sck = 1'b1;
          end
        end
      end
      H_PAUSE: begin
        if (!pause_req) begin
          h_nxt.st     = H_LOW;
          h_nxt.hold_o = 1'b1;
          h_nxt.div    = 2'h0;
        end
      end
      H_HIGH: begin
        h_nxt.div = h_r.div + 2'h1;
        if (h_r.div == HALF_LAST) begin
          h_nxt.div     = 2'h0;
          h_nxt.sck     = 1'b0;
          h_nxt.bit_cnt = h_r.bit_cnt + 4'h1;
          h_nxt.sh      = {h_r.sh[14:0], 1'b0};
          h_nxt.si      = h_r.sh[14];
          if (h_r.bit_cnt[3]) begin
            h_nxt.rd    = {h_r.rd[6:0], h_r.so_s2};
            h_nxt.rd_l3 = {h_r.rd_l3[6:0], h_r.l3_s2};
          end
          if ((role_h == ROLE_LANE) && (h_r.bit_cnt >= BIT_CMD_LAST)) begin
            h_nxt.hold_oe = !h_r.cmd[CMD_READ_BIT];
            h_nxt.hold_o  = h_r.sh[14];
          end
          h_nxt.st = (h_r.bit_cnt == BIT_LAST) ? H_END : H_LOW;
        end
      end
      H_END: begin
        h_nxt.hold_oe = (role_h != ROLE_LANE);
        h_nxt.hold_o  = 1'b1;
        h_nxt.div     = h_r.div + 2'h1;
        if (h_r.div == HALF_LAST) begin
          h_nxt.st   = H_IDLE;
          h_nxt.cs_n = 1'b1;
          h_nxt.done = 1'b1;
          h_nxt.busy = 1'b0;
        end
      end
      H_RST: begin
        h_nxt.rst_cnt = h_r.rst_cnt + 8'h01;
        if (h_r.rst_cnt == RST_LAST) begin
          h_nxt.st     = H_IDLE;
          h_nxt.hold_o = 1'b1;
          h_nxt.busy   = 1'b0;
        end
      end
      default: begin
        h_nxt = H_RST_VAL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      h_r <= H_RST_VAL;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign link.cs_n    = h_r.cs_n;
  assign link.sck     = h_r.sck;
  assign link.si      = h_r.si;
  assign link.hold_o  = h_r.hold_o;
  assign link.hold_oe = h_r.hold_oe;
  assign busy         = h_r.busy;
  assign done         = h_r.done;
  assign rdata        = h_r.rd;
  assign rdata_l3     = h_r.rd_l3;

endmodule : hrlpc_host
`default_nettype wire

// File: tb/hrlpc_link_sva.sv
// Link checker for the pause, reset and lane-three pin
`timescale 1ns/10ps
`default_nettype none
module hrlpc_link_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic quad_lanes_enable_bit,
  input wire logic hold_reset_select,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so_dev,
  input wire logic so_oe,
  input wire logic hold_o,
  input wire logic hold_oe,
  input wire logic lane3_oe
);
  logic       sck_r;
  logic [4:0] rises_r;

  // Counts serial clock rises within a frame
  always_ff @(posedge clk) begin
    sck_r <= sys_rst ? 1'b0 : sck;
    if (sys_rst || cs_n) begin
      rises_r <= 5'h00;
    end else if (sck && !sck_r) begin
      rises_r <= rises_r + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_pin_fall; hold_oe && $fell(hold_o); endsequence
  sequence s_pin_rise; hold_oe && $rose(hold_o); endsequence
  sequence s_paused;
    !cs_n && hold_oe && !hold_o && !quad_lanes_enable_bit && !hold_reset_select;
  endsequence

  property p_enter_low; s_pin_fall |-> !sck; endproperty
  property p_exit_low; s_pin_rise |-> !sck [*2]; endproperty
  property p_paused_quiet; s_paused |-> !so_oe; endproperty
  property p_paused_clock; s_paused |-> !sck; endproperty
  property p_desel_off; cs_n |-> !so_oe; endproperty
  property p_lane_quad; !quad_lanes_enable_bit |-> !lane3_oe; endproperty
  property p_quad_no_pause;
    quad_lanes_enable_bit && hold_oe && !hold_o |-> !cs_n && rises_r >= 5'h08;
  endproperty
  property p_out_on_fall; so_oe && $changed(so_dev) |-> !sck; endproperty
  property p_frame_len; $rose(cs_n) |-> rises_r == 5'h10; endproperty

  a_enter_low: assert property (p_enter_low) else $error("pin fell, clock high");
  a_exit_low: assert property (p_exit_low) else $error("pin rose, clock high");
  a_paused_quiet: assert property (p_paused_quiet) else $error("output on in pause");
  a_paused_clock: assert property (p_paused_clock) else $error("clock ran in pause");
  a_desel_off: assert property (p_desel_off) else $error("output on, deselected");
  a_lane_quad: assert property (p_lane_quad) else $error("lane driven, no quad");
  a_quad_no_pause: assert property (p_quad_no_pause) else $error("pin low in quad");
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved, clock high");
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
endmodule : hrlpc_link_sva
`default_nettype wire

// File: tb/hold_reset_lane_pin_control_tb_top.sv
// Bench joining host end and flash end over the link
`timescale 1ns/10ps
`default_nettype none
module hold_reset_lane_pin_control_tb_top;
  logic       clk, sys_rst, quad_en, hold_sel, start, pause_req, reset_req;
  logic [7:0] cmd, wdata, tx_data, got_cmd, got_dat;
  logic       busy, done, rx_valid, paused, hw_reset_req;
  logic [7:0] rdata, rdata_l3, rx_cmd, rx_data, rx_lane3, got_l3;
  int         err_count, tests_run, i, n;
  integer     seed;

  hrlpc_link_if link ();
  hrlpc_host u_hrlpc_host (.clk(clk), .sys_rst(sys_rst), .link(link.host),
    .quad_lanes_enable_bit(quad_en), .hold_reset_select(hold_sel), .start(start),
    .cmd(cmd), .wdata(wdata), .pause_req(pause_req), .reset_req(reset_req),
    .busy(busy), .done(done), .rdata(rdata), .rdata_l3(rdata_l3));
  hrlpc_device u_hrlpc_device (.clk(clk), .sys_rst(sys_rst), .link(link.dev),
    .quad_lanes_enable_bit(quad_en), .hold_reset_select(hold_sel), .tx_data(tx_data),
    .rx_cmd(rx_cmd), .rx_data(rx_data), .rx_lane3(rx_lane3), .rx_valid(rx_valid),
    .paused(paused), .hw_reset_req(hw_reset_req));
  hrlpc_link_sva u_hrlpc_link_sva (.clk(clk), .sys_rst(sys_rst),
    .quad_lanes_enable_bit(quad_en), .hold_reset_select(hold_sel), .cs_n(link.cs_n),
    .sck(link.sck), .so_dev(link.so_dev), .so_oe(link.so_oe), .hold_o(link.hold_o),
    .hold_oe(link.hold_oe), .lane3_oe(link.lane3_oe));

  // Byte capture, cleared at each frame start
  always @(posedge clk) begin
    if (start === 1'b1) begin
      got_cmd <= 8'hXX;
      got_dat <= 8'hXX;
      got_l3  <= 8'hXX;
    end else if (rx_valid === 1'b1) begin
      got_cmd <= rx_cmd;
      got_dat <= rx_data;
      got_l3  <= rx_lane3;
    end
  end

  // Lane three carries read data or write data
  function automatic logic [7:0] exp_lane3(input logic [7:0] c, input logic [7:0] w,
                                           input logic [7:0] t);
    return c[7] ? t : w;
  endfunction : exp_lane3

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic wait_idle();
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, busy, 1'b0);
      err_count++;
      complete_run();
    end
  endtask : wait_idle

  task automatic frame(input logic [7:0] c, input logic [7:0] w, input logic p);
    cmd = c;
    wdata = w;
    tx_data = 8'($random(seed));
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    if (p) begin
      repeat (c[0] ? 72 : 40) @(negedge clk);
      pause_req = 1'b1;
      repeat (24) @(negedge clk);
      chk({7'h00, paused}, 8'h01);
      chk({7'h00, link.sck}, 8'h00);
      pause_req = 1'b0;
    end
    wait_idle();
    repeat (12) @(negedge clk);
    chk({7'h00, paused}, 8'h00);
    chk(got_cmd, c);
    if (c[7]) chk(rdata, tx_data);
    else chk(got_dat, w);
    if (quad_en) chk(c[7] ? rdata_l3 : got_l3, exp_lane3(c, w, tx_data));
  endtask : frame

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    seed = 43;
    err_count = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    {quad_en, hold_sel, start, pause_req, reset_req} = 5'h00;
    {cmd, wdata, tx_data} = 24'h000000;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    frame(8'h02, 8'hFF, 1'b0);
    frame(8'h80, 8'h00, 1'b1);
    frame(8'h81, 8'h00, 1'b1);
    for (i = 0; i < 8; i++) frame(8'($random(seed)), 8'($random(seed)), i[0]);
    quad_en = 1'b1;
    for (i = 0; i < 4; i++) frame({i[0], 7'($random(seed))}, 8'($random(seed)), 1'b0);
    quad_en = 1'b0;
    hold_sel = 1'b1;
    frame(8'h02, 8'h5A, 1'b0);
    reset_req = 1'b1;
    @(negedge clk);
    reset_req = 1'b0;
    repeat (20) @(negedge clk);
    chk({6'h00, hw_reset_req, paused}, 8'h02);
    wait_idle();
    repeat (4) @(negedge clk);
    chk({7'h00, hw_reset_req}, 8'h00);
    complete_run();
  end
endmodule : hold_reset_lane_pin_control_tb_top
`default_nettype wire
